// ==== rtl/tkf_argmax.v ====
// Purpose: Picks the candidate channel with the largest impedance change.
// Assumes: Deltas are packed, channel 0 in the lowest bits.
// Notes: Ties go to the lowest channel number; no candidate gives zero.
`timescale 1ns/10ps
`default_nettype none
module tkf_argmax #(
  parameter NCH = 16,
  parameter DW = 13
) (
  input wire [NCH-1:0] cand_i,
  input wire [NCH*DW-1:0] delta_i,
  output reg [NCH-1:0] pick_o
);
  integer i;
  reg [DW-1:0] best;
  reg found;
  always @*
  begin
    best = {DW{1'b0}};
    found = 1'b0;
    pick_o = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1)
    begin
      if (cand_i[i] && (!found || delta_i[i*DW +: DW] > best))
      begin
        best = delta_i[i*DW +: DW];
        found = 1'b1;
        pick_o = {NCH{1'b0}};
        pick_o[i] = 1'b1;
      end
    end
  end
endmodule // tkf_argmax
`default_nettype wire

// ==== rtl/tkf_defs.vh ====
// Purpose: Constants of the touchkey filter and proximity block.
// Assumes: Byte-wide register port, 16 channels, 13-bit impedances.
// Notes: Definitions only.
`ifndef TKF_DEFS_VH
`define TKF_DEFS_VH
`define TKF_ADDR_CTRL      8'h90
`define TKF_ADDR_GROUP_LO  8'h92
`define TKF_ADDR_GROUP_HI  8'h93
`define TKF_ADDR_NCFG      8'h96
`define TKF_ADDR_NTHR      8'h97
`define TKF_ADDR_NENV      8'h98
`define TKF_ADDR_FILT_LO   8'h9a
`define TKF_ADDR_FILT_HI   8'h9b
`define TKF_ADDR_NDATA_LO  8'hb0
`define TKF_ADDR_NDATA_HI  8'hb1
`define TKF_ADDR_RAW_LO    8'hb4
`define TKF_ADDR_RAW_HI    8'hb5
`define TKF_RST_BYTE       8'h00
`define TKF_RST_WORD       16'h0000
`define TKF_CTRL_MODE_MSB  1
`define TKF_CTRL_MODE_LSB  0
`define TKF_CTRL_EN_BIT    2
`define TKF_CTRL_CH_MSB    7
`define TKF_CTRL_CH_LSB    4
`define TKF_CFG_DITH_MSB   7
`define TKF_CFG_DITH_LSB   6
`define TKF_CFG_INT_MSB    4
`define TKF_CFG_INT_LSB    2
`define TKF_CFG_ACC_MSB    1
`define TKF_CFG_ACC_LSB    0
`define TKF_ENV_FORCE_BIT  7
`define TKF_ENV_THR_MSB    6
`define TKF_MODE_NONE      2'h0
`define TKF_MODE_ONE       2'h1
`define TKF_MODE_TWO       2'h2
`define TKF_ACC_CAL        2'h1
`define TKF_INT_MAX_CODE   3'h4
`define TKF_DITH_BASE_LOG  3'h2
`define TKF_DITH_SHIFT     2
`define TKF_HYST_SHIFT     2
`define TKF_IMP_MAX        13'h1fff
`endif

// ==== rtl/tkf_top.v ====
// Purpose: Touch bitmaps, key filter and dithered proximity engine with byte registers.
// Assumes: Measurement inputs come from logic on sys_clk_i; host side decodes I2C into reg strobes.
// Notes: Read data appears one cycle after reg_rd_i.
`include "tkf_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module tkf_top #(
  parameter NCH = 16,
  parameter DW = 13,
  parameter TW = 9
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  input wire [NCH*DW-1:0] chan_imp_i,
  input wire [NCH*DW-1:0] chan_cal_i,
  input wire [NCH*TW-1:0] chan_thr_i,
  input wire meas_done_i,
  output wire [NCH-1:0] raw_touch_o,
  output wire [NCH-1:0] filtered_key_o,
  output wire near_status_o
);
  reg [7:0] ctrl_r;
  reg [15:0] group_r;
  reg [7:0] ncfg_r;
  reg [7:0] nthr_r;
  reg [7:0] nenv_r;
  reg [NCH-1:0] raw_r;
  reg [NCH-1:0] filt_r;
  reg [NCH*DW-1:0] delta;
  reg [DW+5:0] acc_r;
  reg [5:0] dcnt_r;
  reg [DW-1:0] dith_r;
  reg [DW-1:0] ncal_r;
  reg [4:0] icnt_r;
  reg force_pend_r;
  reg cal_done_r;
  reg near_r;
  reg [7:0] rd_nxt;
  wire [1:0] mode = ctrl_r[`TKF_CTRL_MODE_MSB:`TKF_CTRL_MODE_LSB];
  wire near_en = ctrl_r[`TKF_CTRL_EN_BIT];
  wire [3:0] near_channel_pick = ctrl_r[`TKF_CTRL_CH_MSB:`TKF_CTRL_CH_LSB];
  wire [1:0] dith_code = ncfg_r[`TKF_CFG_DITH_MSB:`TKF_CFG_DITH_LSB];
  wire [2:0] int_code = ncfg_r[`TKF_CFG_INT_MSB:`TKF_CFG_INT_LSB];
  wire [1:0] acc_mode = ncfg_r[`TKF_CFG_ACC_MSB:`TKF_CFG_ACC_LSB];
  wire force_bit = nenv_r[`TKF_ENV_FORCE_BIT];
  wire [6:0] env_thr = nenv_r[`TKF_ENV_THR_MSB:0];
  wire [DW-1:0] sel_imp = chan_imp_i[near_channel_pick*DW +: DW];
  wire [2:0] dith_log = {1'b0, dith_code} + `TKF_DITH_BASE_LOG;
  wire [5:0] dith_len = 6'h01 << dith_log;
  wire [2:0] int_eff = (int_code > `TKF_INT_MAX_CODE) ? `TKF_INT_MAX_CODE : int_code;
  wire [4:0] int_len = 5'h01 << int_eff;
  wire [DW+5:0] acc_sum = acc_r + {6'h00, sel_imp};
  wire [DW+5:0] acc_scaled = acc_sum >> `TKF_DITH_SHIFT;
  wire [DW-1:0] dith_new = (|acc_scaled[DW+5:DW]) ? `TKF_IMP_MAX : acc_scaled[DW-1:0];
  wire dith_last = (dcnt_r + 6'h01) == dith_len;
  wire [DW-1:0] near_diff = (dith_r > ncal_r) ? dith_r - ncal_r : ncal_r - dith_r;
  wire [DW-1:0] new_diff = (dith_new > ncal_r) ? dith_new - ncal_r : ncal_r - dith_new;
  wire [DW-1:0] near_data = (acc_mode == `TKF_ACC_CAL) ? ncal_r : dith_r;
  wire [15:0] near_port = {near_r, cal_done_r, 1'b0, near_data};

  // Per-channel magnitude of impedance change and hysteresis compare.
  integer c;
  reg [NCH-1:0] raw_nxt;
  reg [DW-1:0] d;
  reg [TW-1:0] t;
  always @*
  begin
    delta = {NCH*DW{1'b0}};
    raw_nxt = raw_r;
    for (c = 0; c < NCH; c = c + 1)
    begin
      d = (chan_imp_i[c*DW +: DW] > chan_cal_i[c*DW +: DW]) ?
          chan_imp_i[c*DW +: DW] - chan_cal_i[c*DW +: DW] :
          chan_cal_i[c*DW +: DW] - chan_imp_i[c*DW +: DW];
      t = chan_thr_i[c*TW +: TW];
      delta[c*DW +: DW] = d;
      if ({{DW-TW{1'b0}}, t} < d)
        raw_nxt[c] = 1'b1;
      else if ({{DW-TW{1'b0}}, t - (t >> `TKF_HYST_SHIFT)} >= d)
        raw_nxt[c] = 1'b0;
    end
  end

  // Key filter: three chained picks of the largest change within the group.
  wire [NCH-1:0] cand1 = raw_r & group_r[NCH-1:0];
  wire [NCH-1:0] pick1;
  wire [NCH-1:0] pick2;
  wire [NCH-1:0] pick3;
  reg [NCH*DW-1:0] delta_r;
  tkf_argmax #(.NCH(NCH), .DW(DW)) u_pick1 (
    .cand_i(cand1),
    .delta_i(delta_r),
    .pick_o(pick1)
  );
  tkf_argmax #(.NCH(NCH), .DW(DW)) u_pick2 (
    .cand_i(cand1 & ~pick1),
    .delta_i(delta_r),
    .pick_o(pick2)
  );
  tkf_argmax #(.NCH(NCH), .DW(DW)) u_pick3 (
    .cand_i(cand1 & ~pick1 & ~pick2),
    .delta_i(delta_r),
    .pick_o(pick3)
  );
  reg [NCH-1:0] kept;
  always @*
  begin
    case (mode)
      `TKF_MODE_NONE: kept = cand1;
      `TKF_MODE_ONE: kept = pick1;
      `TKF_MODE_TWO: kept = pick1 | pick2;
      default: kept = pick1 | pick2 | pick3;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      raw_r <= `TKF_RST_WORD;
      delta_r <= {NCH*DW{1'b0}};
      filt_r <= `TKF_RST_WORD;
    end
    else
    begin
      raw_r <= raw_nxt;
      delta_r <= delta;
      filt_r <= (raw_r & ~group_r[NCH-1:0]) | kept;
    end
  end

  // Register writes.
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= `TKF_RST_BYTE;
      group_r <= `TKF_RST_WORD;
      ncfg_r <= `TKF_RST_BYTE;
      nthr_r <= `TKF_RST_BYTE;
      nenv_r <= `TKF_RST_BYTE;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `TKF_ADDR_CTRL: ctrl_r <= reg_wdata_i;
        `TKF_ADDR_GROUP_LO: group_r[7:0] <= reg_wdata_i;
        `TKF_ADDR_GROUP_HI: group_r[15:8] <= reg_wdata_i;
        `TKF_ADDR_NCFG: ncfg_r <= reg_wdata_i;
        `TKF_ADDR_NTHR: nthr_r <= reg_wdata_i;
        `TKF_ADDR_NENV: nenv_r <= reg_wdata_i;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Proximity engine: accumulate samples of the chosen channel, then track the reference.
  wire force_wr = reg_wr_i && (reg_addr_i == `TKF_ADDR_NENV) && reg_wdata_i[`TKF_ENV_FORCE_BIT] && !force_bit;
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      acc_r <= {DW+6{1'b0}};
      dcnt_r <= 6'h00;
      dith_r <= {DW{1'b0}};
      ncal_r <= {DW{1'b0}};
      icnt_r <= 5'h00;
      force_pend_r <= 1'b0;
      cal_done_r <= 1'b0;
      near_r <= 1'b0;
    end
    else if (!near_en)
    begin
      acc_r <= {DW+6{1'b0}};
      dcnt_r <= 6'h00;
      icnt_r <= 5'h00;
      near_r <= 1'b0;
      if (force_wr)
        force_pend_r <= 1'b1;
      if (force_wr)
        cal_done_r <= 1'b0;
    end
    else
    begin
      if (force_wr)
      begin
        force_pend_r <= 1'b1;
        cal_done_r <= 1'b0;
      end
      near_r <= near_diff > {{DW-8{1'b0}}, nthr_r};
      if (meas_done_i)
      begin
        if (dith_last)
        begin
          acc_r <= {DW+6{1'b0}};
          dcnt_r <= 6'h00;
          dith_r <= dith_new;
          if (force_pend_r && !force_wr)
          begin
            ncal_r <= dith_new;
            force_pend_r <= 1'b0;
            cal_done_r <= 1'b1;
            icnt_r <= 5'h00;
          end
          else if ((icnt_r + 5'h01) == int_len)
          begin
            icnt_r <= 5'h00;
            if (new_diff < {{DW-7{1'b0}}, env_thr})
              ncal_r <= dith_new;
          end
          else
            icnt_r <= icnt_r + 5'h01;
        end
        else
        begin
          acc_r <= acc_sum;
          dcnt_r <= dcnt_r + 6'h01;
        end
      end
    end
  end

  // Register reads, one cycle after the strobe.
  always @*
  begin
    case (reg_addr_i)
      `TKF_ADDR_CTRL: rd_nxt = ctrl_r;
      `TKF_ADDR_GROUP_LO: rd_nxt = group_r[7:0];
      `TKF_ADDR_GROUP_HI: rd_nxt = group_r[15:8];
      `TKF_ADDR_NCFG: rd_nxt = ncfg_r;
      `TKF_ADDR_NTHR: rd_nxt = nthr_r;
      `TKF_ADDR_NENV: rd_nxt = nenv_r;
      `TKF_ADDR_FILT_LO: rd_nxt = filt_r[7:0];
      `TKF_ADDR_FILT_HI: rd_nxt = filt_r[15:8];
      `TKF_ADDR_NDATA_LO: rd_nxt = near_port[7:0];
      `TKF_ADDR_NDATA_HI: rd_nxt = near_port[15:8];
      `TKF_ADDR_RAW_LO: rd_nxt = raw_r[7:0];
      `TKF_ADDR_RAW_HI: rd_nxt = raw_r[15:8];
      default: rd_nxt = `TKF_RST_BYTE;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= `TKF_RST_BYTE;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rd_nxt;
    end
  end

  assign raw_touch_o = raw_r;
  assign filtered_key_o = filt_r;
  assign near_status_o = near_r;
endmodule // tkf_top
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: Register-level tests of touch bitmaps, key filter and proximity.
// Assumes: One idle cycle between register accesses.
// Notes: Expected values follow from the front end model deltas.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst, wr, rd, rv, nst, md;
  logic [7:0] addr, wd, rdat, v;
  logic [15:0] press, raw, filt;
  logic [207:0] imp, cal;
  logic [143:0] thr;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [7:0] ra [13] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h96, 8'h97, 8'h98, 8'h9a, 8'h9b, 8'hb0, 8'hb1, 8'hb4, 8'hb5};
  logic [7:0] fx [4] = '{8'h27, 8'h20, 8'h24, 8'h26};
  always #2.5 clk = ~clk;
  tkf_meas_model tkf_meas_model_i (.clk_i(clk), .rst_i(rst), .press_i(press), .imp_o(imp), .cal_o(cal),
    .thr_o(thr), .done_o(md));
  tkf_top #(.NCH(16), .DW(13), .TW(9)) tkf_top_i (.sys_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .reg_rvalid_o(rv), .chan_imp_i(imp),
    .chan_cal_i(cal), .chan_thr_i(thr), .meas_done_i(md), .raw_touch_o(raw), .filtered_key_o(filt),
    .near_status_o(nst));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    addr = a;
    wd = d;
    wr = 1'b1;
    @(posedge clk) #1;
    wr = 1'b0;
  endtask
  task automatic rd_b(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk) #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk) #1;
    rd = 1'b0;
    r = rv === 1'b1 ? rdat : 8'hxx;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd_b(a, v);
    chk(v, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop;
  end
  initial
  begin
    {rst, wr, rd, addr, wd, press} = {1'b1, 34'h0};
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    foreach (ra[i]) rd_chk(ra[i], 8'h00);
    $display("test reset done");
    wr_b(8'h97, 8'h10);
    wr_b(8'h98, 8'h03);
    wr_b(8'hb4, 8'hff);
    rd_chk(8'h97, 8'h10);
    rd_chk(8'h98, 8'h03);
    rd_chk(8'hb4, 8'h00);
    $display("test registers done");
    press = 16'h0227;
    wr_b(8'h92, 8'hff);
    for (int m = 0; m < 4; m++)
    begin
      wr_b(8'h90, 8'(m));
      repeat (4) @(posedge clk);
      rd_chk(8'h9a, fx[m]);
      rd_chk(8'h9b, 8'h02);
    end
    wr_b(8'h93, 8'h02);
    wr_b(8'h90, 8'h01);
    repeat (4) @(posedge clk);
    rd_chk(8'h9a, 8'h00);
    rd_chk(8'h9b, 8'h02);
    rd_chk(8'hb4, 8'h27);
    rd_chk(8'hb5, 8'h02);
    chk(raw[7:0], 8'h27);
    chk(filt[15:8], 8'h02);
    $display("test key filter done");
    press = 16'h0008;
    wr_b(8'h96, 8'h00);
    wr_b(8'h90, 8'h34);
    repeat (40) @(posedge clk);
    rd_chk(8'hb0, 8'ha4);
    rd_chk(8'hb1, 8'h8f);
    chk({7'h00, nst}, 8'h01);
    wr_b(8'h98, 8'h83);
    v = 8'h00;
    for (int k = 0; k < 50 && v[6] !== 1'b1; k++) rd_b(8'hb1, v);
    chk(v & 8'h40, 8'h40);
    wr_b(8'h98, 8'h03);
    wr_b(8'h96, 8'h01);
    repeat (8) @(posedge clk);
    rd_chk(8'hb0, 8'ha4);
    rd_chk(8'hb1, 8'h4f);
    wr_b(8'h90, 8'h30);
    repeat (4) @(posedge clk);
    rd_chk(8'hb1, 8'h4f);
    wr_b(8'h96, 8'h40);
    wr_b(8'h90, 8'h34);
    repeat (60) @(posedge clk);
    rd_chk(8'hb0, 8'h48);
    rd_chk(8'hb1, 8'hdf);
    wr_b(8'h90, 8'h30);
    repeat (4) @(posedge clk);
    rd_chk(8'hb1, 8'h5f);
    wr_b(8'h98, 8'h83);
    rd_chk(8'hb1, 8'h1f);
    $display("test proximity done");
    report_and_stop;
  end
endmodule // tb
bind tkf_top tkf_top_assertions #(.NCH(NCH), .DW(DW), .TW(TW)) chk_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .chan_imp_i(chan_imp_i), .chan_cal_i(chan_cal_i),
  .chan_thr_i(chan_thr_i), .meas_done_i(meas_done_i), .raw_touch_o(raw_touch_o),
  .filtered_key_o(filtered_key_o), .near_status_o(near_status_o));
`default_nettype wire

// ==== sim/tkf_meas_model.sv ====
// Purpose: Measurement front end feeding impedances and sample pulses.
// Assumes: Pressed channel n drops by 0x50 + 4n from a 0x1000 reference.
// Notes: Higher channels show larger changes, so ranking is known.
`timescale 1ns/10ps
`default_nettype none
module tkf_meas_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] press_i,
  output logic [207:0] imp_o,
  output logic [207:0] cal_o,
  output logic [143:0] thr_o,
  output logic done_o
);
  logic [1:0] cnt_r;
  always_comb
  begin
    for (int n = 0; n < 16; n++)
    begin
      imp_o[n*13+:13] = press_i[n] ? 13'h1000 - 13'h50 - 13'(n * 4) : 13'h1000;
      cal_o[n*13+:13] = 13'h1000;
      thr_o[n*9+:9] = 9'h040;
    end
  end
  always @(posedge clk_i)
    cnt_r <= rst_i ? 2'h0 : cnt_r + 2'h1;
  assign done_o = cnt_r == 2'h3;
endmodule // tkf_meas_model
`default_nettype wire

// ==== sim/tkf_top_assertions.sv ====
// Purpose: Port-level checker for the touch filter and proximity block.
// Assumes: Register writes mirrored here land on the same edge as in the block.
// Notes: Only channel 0 is checked for the touch compare.
`timescale 1ns/10ps
`default_nettype none
module tkf_top_assertions #(
  parameter NCH = 16,
  parameter DW = 13,
  parameter TW = 9
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [NCH*DW-1:0] chan_imp_i,
  input wire logic [NCH*DW-1:0] chan_cal_i,
  input wire logic [NCH*TW-1:0] chan_thr_i,
  input wire logic meas_done_i,
  input wire logic [NCH-1:0] raw_touch_o,
  input wire logic [NCH-1:0] filtered_key_o,
  input wire logic near_status_o
);
  logic [1:0] mode_r;
  logic en_r;
  logic [15:0] grp_r;
  logic [12:0] d0;
  logic [12:0] t0;
  assign d0 = chan_imp_i[12:0] > chan_cal_i[12:0] ? chan_imp_i[12:0] - chan_cal_i[12:0]
    : chan_cal_i[12:0] - chan_imp_i[12:0];
  assign t0 = {4'h0, chan_thr_i[8:0]};
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= 2'h0;
      en_r <= 1'b0;
      grp_r <= 16'h0000;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == 8'h90)
      begin
        mode_r <= reg_wdata_i[1:0];
        en_r <= reg_wdata_i[2];
      end
      if (reg_addr_i == 8'h92)
        grp_r[7:0] <= reg_wdata_i;
      if (reg_addr_i == 8'h93)
        grp_r[15:8] <= reg_wdata_i;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_answer;
    ##1 reg_rvalid_o;
  endsequence
  a_read_answer: assert property (reg_rd_i |-> s_answer)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("answer without read");
  a_rdata_holds: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved");
  a_touch_set: assert property (d0 > t0 |=> raw_touch_o[0])
    else $error("touch not raised");
  a_touch_clear: assert property (d0 <= t0 - {2'h0, t0[12:2]} |=> !raw_touch_o[0])
    else $error("touch not released");
  a_near_off: assert property (!en_r && !$past(en_r) |-> !near_status_o)
    else $error("proximity status while off");
  a_filt_none: assert property ($past(mode_r) == 2'h0 |-> filtered_key_o == $past(raw_touch_o))
    else $error("unfiltered output differs");
  a_filt_pass: assert property ((filtered_key_o & ~$past(grp_r)) == ($past(raw_touch_o) & ~$past(grp_r)))
    else $error("ungrouped channel altered");
  a_filt_limit: assert property ($past(mode_r) != 2'h0 |->
    $countones(filtered_key_o & $past(grp_r)) <= $past(mode_r) && !(filtered_key_o & ~$past(raw_touch_o)))
    else $error("too many grouped keys");
endmodule // tkf_top_assertions
`default_nettype wire
